// [dv/baro_readout_asserts.sv]
// concurrent checks on the pins of the conversion and result readout block
module baro_readout_asserts (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_n_o,
    input  wire logic busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import baro_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    localparam int BUSY_MIN = CONV_UNIT_CYC;
    localparam int BUSY_MAX = (CONV_UNIT_CYC << RATIO_MAX) + 4;

    logic [CONV_CNT_W:0] busy_cnt_q;

    // length of the running conversion; a counter because it exceeds any repetition
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt_q <= '0;
        end else if (busy_o) begin
            busy_cnt_q <= busy_cnt_q + 1'b1;
        end else begin
            busy_cnt_q <= '0;
        end
    end

    sequence scl_low_s;
        !scl_i;
    endsequence
    sequence stop_s;
        scl_i && $rose(sda_i);
    endsequence

    chk_sda_value_low: assert property (sda_o == 1'b0)
        else $error("data pin value not low");
    chk_drive_scl_low: assert property ($changed(sda_oe_n_o) |-> scl_low_s)
        else $error("data enable moved while clock high");
    chk_drive_holds: assert property ($changed(sda_oe_n_o) |=> $stable(sda_oe_n_o)[*4])
        else $error("data enable did not stand");
    chk_busy_start: assert property ($rose(busy_o) |-> scl_low_s)
        else $error("conversion started outside a command acknowledge");
    chk_busy_in_ack: assert property ($rose(busy_o) |-> !sda_oe_n_o)
        else $error("conversion started while the command byte was not acknowledged");
    chk_busy_min_len: assert property ($fell(busy_o) |-> busy_cnt_q >= BUSY_MIN)
        else $error("conversion ended too early");
    chk_busy_max_len: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("conversion ran too long");
    chk_busy_gap: assert property ($fell(busy_o) |=> (!busy_o)[*8])
        else $error("busy came back without a command");
    chk_stop_released: assert property (stop_s |=> sda_oe_n_o[*2])
        else $error("data pin driven after stop");
endmodule : baro_readout_asserts

bind baro_readout baro_readout_asserts u_baro_readout_asserts (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));

// [dv/i2c_host.sv]
// behavioural bus master that issues frames to the readout block
module i2c_host (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 8;  // clock phases well above the sync delay

    // clock idles high and data released: the line rests on its pull-up
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // also serves as repeated start, since data is released with clock low first
    task automatic start_bit();
        sda_oe_n_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_oe_n_o = 1'b0;
        tick(HALF);
        scl_o = 1'b0;
        tick(2);
    endtask : start_bit

    task automatic stop_bit();
        sda_oe_n_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_oe_n_o = 1'b1;
        tick(HALF);
    endtask : stop_bit

    // data set with clock low, sampled at the end of the high phase
    task automatic send_bit(input logic b, output logic got);
        sda_oe_n_o = b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        got = sda_i;
        scl_o = 1'b0;
        tick(2);
    endtask : send_bit

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], g);
        end
        send_bit(1'b1, g);
        ack = ~g;
    endtask : write_byte

    // eight clocks of data, then our own acknowledge or not-acknowledge
    task automatic read_byte(input logic last, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b1, g);
            b[i] = g;
        end
        send_bit(last, g);
    endtask : read_byte
endmodule : i2c_host

// [dv/tb.sv]
// self-checking bench for the conversion and result readout block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import baro_pkg::*;

    logic                mclk_i;
    logic                arst_n_i;
    logic                scl;
    logic                sda;
    logic                sda_o;
    logic                dev_oe_n;
    logic                host_oe_n;
    logic                busy_o;
    logic [RESULT_W-1:0] press_smp;
    logic [RESULT_W-1:0] temp_smp;
    int                  n_mismatch = 0;
    int                  n_compared = 0;

    // open-drain wire with pull-up: low when either side enables its driver
    assign sda = (dev_oe_n | sda_o) & host_oe_n;

    baro_readout u_baro_readout (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(dev_oe_n), .pressure_sample_i(press_smp),
        .temperature_sample_i(temp_smp), .busy_o(busy_o));
    i2c_host u_i2c_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(host_oe_n));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic cmp_result(input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_result

    task automatic cmp_flag(input logic exp, input logic got);
        cmp_result({23'h000000, exp}, {23'h000000, got});
    endtask : cmp_flag

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic send_cmd(input logic [7:0] cmd, output logic ack);
        logic a0;
        u_i2c_host.start_bit();
        u_i2c_host.write_byte({DEV_ADDR, 1'b0}, a0);
        u_i2c_host.write_byte(cmd, ack);
        u_i2c_host.stop_bit();
        ack = ack & a0;
    endtask : send_cmd

    // result read: command frame, then a read frame of three bytes, the last one refused
    task automatic read_result(output logic [23:0] r);
        logic a;
        send_cmd(CMD_READ_RESULT, a);
        u_i2c_host.start_bit();
        u_i2c_host.write_byte({DEV_ADDR, 1'b1}, a);
        u_i2c_host.read_byte(1'b0, r[23:16]);
        u_i2c_host.read_byte(1'b0, r[15:8]);
        u_i2c_host.read_byte(1'b1, r[7:0]);
        u_i2c_host.stop_bit();
    endtask : read_result

    // bounded so a stuck busy shows up as a mismatch, not a hang
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 4000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        cmp_flag(1'b0, busy_o);
    endtask : wait_idle

    task automatic t_after_reset();
        logic [23:0] r;
        cmp_flag(1'b1, dev_oe_n);
        cmp_flag(1'b0, busy_o);
        read_result(r);
        cmp_result(24'h000000, r);
        $display("test after_reset done");
    endtask : t_after_reset

    // every conversion code of both channels, each followed by a read and a repeat
    task automatic t_all_codes();
        logic [23:0] r;
        logic [7:0]  cmd;
        logic        a;
        for (int i = 0; i < 12; i++) begin
            cmd = {(i < 6) ? CMD_PRESS_NIB : CMD_TEMP_NIB, 3'(i % 6), 1'b0};
            press_smp = 24'h8C3A51 + 24'(i);
            temp_smp = 24'h1F0E2D + 24'(i);
            send_cmd(cmd, a);
            cmp_flag(1'b1, a);
            cmp_flag(1'b1, busy_o);
            wait_idle();
            read_result(r);
            cmp_result((i < 6) ? press_smp : temp_smp, r);
            read_result(r);
            cmp_result(24'h000000, r);
        end
        $display("test all_codes done");
    endtask : t_all_codes

    // longest ratio so the whole read lands inside the conversion
    task automatic t_read_busy();
        logic [23:0] r;
        logic        a;
        press_smp = 24'h3C5A96;
        send_cmd({CMD_PRESS_NIB, RATIO_MAX, 1'b0}, a);
        read_result(r);
        cmp_result(24'h000000, r);
        cmp_flag(1'b1, busy_o);
        wait_idle();
        read_result(r);
        cmp_result(press_smp ^ CORRUPT_MASK, r);
        $display("test read_busy done");
    endtask : t_read_busy

    // second conversion command while one runs: not a restart, but the result is spoilt
    task automatic t_conv_busy();
        logic [23:0] r;
        logic        a;
        temp_smp = 24'h2B4D6F;
        press_smp = 24'h7E1C3A;
        send_cmd({CMD_TEMP_NIB, RATIO_MAX, 1'b0}, a);
        send_cmd({CMD_PRESS_NIB, 3'h0, 1'b0}, a);
        cmp_flag(1'b1, a);
        cmp_flag(1'b1, busy_o);
        wait_idle();
        read_result(r);
        cmp_result(temp_smp ^ CORRUPT_MASK, r);
        $display("test conv_busy done");
    endtask : t_conv_busy

    task automatic t_refused();
        logic a;
        u_i2c_host.start_bit();
        u_i2c_host.write_byte({DEV_ADDR ^ 7'h01, 1'b0}, a);
        u_i2c_host.stop_bit();
        cmp_flag(1'b0, a);
        send_cmd(8'h41, a);
        cmp_flag(1'b1, a);
        cmp_flag(1'b0, busy_o);
        send_cmd(8'h4C, a);
        cmp_flag(1'b1, a);
        cmp_flag(1'b0, busy_o);
        $display("test refused done");
    endtask : t_refused

    initial begin
        arst_n_i = 1'b0;
        press_smp = 24'h000000;
        temp_smp = 24'h000000;
        repeat (16) @(posedge mclk_i);
        #1;
        arst_n_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        t_after_reset();
        t_all_codes();
        t_read_busy();
        t_conv_busy();
        t_refused();
        give_verdict();
    end

    // the whole sequence needs about 54000 cycles
    initial begin
        repeat (80000) @(posedge mclk_i);
        n_mismatch++;
        give_verdict();
    end
endmodule : tb

// [hw/baro_pkg.sv]
// constants, command codes and state types for the conversion and result readout block
//
// Behaviour
// - a conversion command starts a raw pressure or raw temperature conversion as selected.
// - a result read after a finished conversion is shifted out most significant bit first.
// - a result read with no conversion before it, or a repeated read, returns all zeros.
// - a result read while a conversion runs returns zero.
// - a result read during a conversion does not stop it but spoils its final value.
// - after taking a conversion command the block stays busy until the conversion is done.
// - each 8 data bits are followed by an acknowledge slot that is awaited before the next byte.
// - commands are one byte: 0x40-0x4A pressure, 0x50-0x5A temperature, 0x00 result read.
// - the bus address is 1110110, with direction bit 0 for write and 1 for read.
// - a result read answers with a 24-bit value.
package baro_pkg;

    // ----------------------------------------------------------------
    // bus framing
    // ----------------------------------------------------------------
    localparam logic [6:0]  DEV_ADDR        = 7'h76;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam int          RESULT_W        = 24;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_READ_RESULT = 8'h00;
    localparam logic [3:0]  CMD_PRESS_NIB   = 4'h4;
    localparam logic [3:0]  CMD_TEMP_NIB    = 4'h5;
    localparam logic [2:0]  RATIO_MAX       = 3'h5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          CONV_UNIT_NS    = 1000;   // conversion time of the lowest ratio
    localparam int          CONV_UNIT_CYC   = CONV_UNIT_NS / CLK_PERIOD_NS;
    localparam int          CONV_CNT_W      = 12;

    // ----------------------------------------------------------------
    // result handling
    // ----------------------------------------------------------------
    localparam logic [23:0] CORRUPT_MASK    = 24'h5A5A5A;
    localparam logic [23:0] RESULT_RESET    = 24'h000000;

    typedef enum logic [0:0] {
        CH_PRESSURE    = 1'b0,
        CH_TEMPERATURE = 1'b1
    } channel_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_BYTE  = 3'b011,
        ST_WR_ACK   = 3'b100,
        ST_RD_BYTE  = 3'b101,
        ST_RD_ACK   = 3'b110
    } bus_state_t;

endpackage : baro_pkg

// [hw/baro_readout.sv]
// i2c slave front end: command decode, busy tracking and 24-bit result readout
module baro_readout (
    input  wire logic                          mclk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          scl_i,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe_n_o,
    input  wire logic [baro_pkg::RESULT_W-1:0] pressure_sample_i,
    input  wire logic [baro_pkg::RESULT_W-1:0] temperature_sample_i,
    output logic                               busy_o
);
    import baro_pkg::*;

    conv_if cv ();

    logic [1:0]          scl_sync_q;
    logic [1:0]          sda_sync_q;
    logic                scl_prev_q;
    logic                sda_prev_q;
    logic                scl_rise;
    logic                scl_fall;
    logic                bus_start;
    logic                bus_stop;
    bus_state_t          state_q;
    logic [3:0]          bit_cnt_q;
    logic [7:0]          rx_q;
    logic [RESULT_W-1:0] tx_q;
    logic                read_dir_q;
    logic                master_ack_q;
    logic                result_valid_q;
    logic                read_armed_q;
    logic                start_q;
    channel_t            chan_q;
    logic [2:0]          ratio_q;
    logic                corrupt_q;
    logic                cmd_done;
    logic                is_conv_cmd;

    // ----------------------------------------------------------------
    // pin synchronisers and bus event detection
    // ----------------------------------------------------------------
    // edges are taken from the second stage only, never the first
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign scl_rise  = scl_sync_q[1] & ~scl_prev_q;
    assign scl_fall  = ~scl_sync_q[1] & scl_prev_q;
    assign bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign bus_stop  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

    // a command byte is complete on the falling edge after its eighth bit
    assign cmd_done    = (state_q == ST_WR_BYTE) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
    assign is_conv_cmd = ((rx_q[7:4] == CMD_PRESS_NIB) || (rx_q[7:4] == CMD_TEMP_NIB)) &&
                         !rx_q[0] && (rx_q[3:1] <= RATIO_MAX);

    // ----------------------------------------------------------------
    // bus state machine and bit counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q      <= ST_IDLE;
            bit_cnt_q    <= '0;
            read_dir_q   <= 1'b0;
            master_ack_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= ST_IDLE;
        end else if (bus_start) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bit_cnt_q <= '0;
                end
                ST_ADDR: begin
                    if (scl_rise)
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        if (rx_q[7:1] == DEV_ADDR) begin
                            state_q    <= ST_ADDR_ACK;
                            read_dir_q <= rx_q[0];
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= '0;
                        state_q   <= read_dir_q ? ST_RD_BYTE : ST_WR_BYTE;
                    end
                end
                ST_WR_BYTE: begin
                    if (scl_rise)
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    else if (cmd_done)
                        state_q <= ST_WR_ACK;
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= '0;
                        state_q   <= ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise)
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    else if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
                        state_q <= ST_RD_ACK;
                end
                ST_RD_ACK: begin
                    if (scl_rise)
                        master_ack_q <= ~sda_sync_q[1];
                    else if (scl_fall) begin
                        bit_cnt_q <= '0;
                        state_q   <= master_ack_q ? ST_RD_BYTE : ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive and transmit shift registers
    // ----------------------------------------------------------------
    // bytes beyond the third shift out zeros, so an over-long read stays harmless
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_q <= '0;
            tx_q <= RESULT_RESET;
        end else begin
            if (scl_rise && (state_q == ST_ADDR || state_q == ST_WR_BYTE))
                rx_q <= {rx_q[6:0], sda_sync_q[1]};
            if (state_q == ST_ADDR_ACK && scl_fall && read_dir_q)
                tx_q <= read_armed_q ? cv.result : RESULT_RESET;
            else if (state_q == ST_RD_BYTE && scl_fall && bit_cnt_q != '0)
                tx_q <= {tx_q[RESULT_W-2:0], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // open-drain data driver
    // ----------------------------------------------------------------
    // updated on falling clock edges, and released at a start or stop, so data is stable while scl is high
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else if (bus_stop || bus_start) begin
            sda_oe_n_o <= 1'b1;
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR:     sda_oe_n_o <= !(bit_cnt_q == BITS_PER_BYTE &&
                                             rx_q[7:1] == DEV_ADDR);
                ST_ADDR_ACK: sda_oe_n_o <= read_dir_q ?
                                           (read_armed_q ? cv.result[RESULT_W-1] : 1'b0) :
                                           1'b1;
                ST_WR_BYTE:  sda_oe_n_o <= (bit_cnt_q != BITS_PER_BYTE);
                ST_RD_BYTE:  sda_oe_n_o <= (bit_cnt_q == BITS_PER_BYTE) ? 1'b1 :
                                           tx_q[RESULT_W-2];
                ST_RD_ACK:   sda_oe_n_o <= master_ack_q ? tx_q[RESULT_W-1] : 1'b1;
                default:     sda_oe_n_o <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // command decode and result bookkeeping
    // ----------------------------------------------------------------
    // a finished conversion wins over a clear arriving in the same cycle
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q        <= 1'b0;
            chan_q         <= CH_PRESSURE;
            ratio_q        <= '0;
            corrupt_q      <= 1'b0;
            result_valid_q <= 1'b0;
            read_armed_q   <= 1'b0;
        end else begin
            start_q   <= 1'b0;
            corrupt_q <= 1'b0;
            if (cmd_done && is_conv_cmd) begin
                start_q <= 1'b1;
                chan_q  <= (rx_q[7:4] == CMD_TEMP_NIB) ? CH_TEMPERATURE : CH_PRESSURE;
                ratio_q <= rx_q[3:1];
            end
            if (cmd_done && rx_q == CMD_READ_RESULT) begin
                read_armed_q <= result_valid_q && !cv.busy;
                corrupt_q    <= cv.busy;
            end else if (state_q == ST_ADDR_ACK && scl_fall && read_dir_q) begin
                read_armed_q <= 1'b0;
            end
            if (cv.done)
                result_valid_q <= 1'b1;
            else if ((cmd_done && rx_q == CMD_READ_RESULT) || cv.busy)
                result_valid_q <= 1'b0;
        end
    end

    assign cv.start              = start_q;
    assign cv.channel            = chan_q;
    assign cv.oversampling_ratio = ratio_q;
    assign cv.corrupt            = corrupt_q;
    assign busy_o                = cv.busy;

    // ----------------------------------------------------------------
    // conversion engine
    // ----------------------------------------------------------------
    conv_engine u_engine (
        .mclk_i               (mclk_i),
        .arst_n_i             (arst_n_i),
        .cv                   (cv.engine),
        .pressure_sample_i    (pressure_sample_i),
        .temperature_sample_i (temperature_sample_i)
    );

endmodule : baro_readout

// [hw/conv_engine.sv]
// conversion engine: times one conversion and captures the sampled channel
module conv_engine (
    input  wire logic                        mclk_i,
    input  wire logic                        arst_n_i,
    conv_if.engine                           cv,
    input  wire logic [baro_pkg::RESULT_W-1:0] pressure_sample_i,
    input  wire logic [baro_pkg::RESULT_W-1:0] temperature_sample_i
);
    import baro_pkg::*;

    logic [CONV_CNT_W-1:0] cnt_q;
    logic                  busy_q;
    logic                  done_q;
    logic                  spoil_q;
    channel_t              chan_q;
    logic [RESULT_W-1:0]   result_q;
    logic [RESULT_W-1:0]   sample;

    assign cv.busy   = busy_q;
    assign cv.done   = done_q;
    assign cv.result = result_q;
    assign sample    = (chan_q == CH_TEMPERATURE) ? temperature_sample_i : pressure_sample_i;

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    // a start while busy is not honoured; the run continues but is spoilt
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            chan_q <= CH_PRESSURE;
        end else begin
            done_q <= 1'b0;
            if (cv.start && !busy_q) begin
                busy_q <= 1'b1;
                chan_q <= cv.channel;
                cnt_q  <= CONV_CNT_W'((CONV_UNIT_CYC << cv.oversampling_ratio) - 1);
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // spoil tracking and result capture
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            spoil_q  <= 1'b0;
            result_q <= RESULT_RESET;
        end else begin
            if (cv.start && !busy_q)
                spoil_q <= 1'b0;
            else if (busy_q && (cv.corrupt || cv.start))
                spoil_q <= 1'b1;
            if (busy_q && cnt_q == '0)
                result_q <= (spoil_q || cv.corrupt || cv.start) ?
                            (sample ^ CORRUPT_MASK) : sample;
        end
    end

endmodule : conv_engine

// [hw/conv_if.sv]
// carrier between the bus front end and the conversion engine
interface conv_if;
    import baro_pkg::*;

    logic                start;
    channel_t            channel;
    logic [2:0]          oversampling_ratio;
    logic                corrupt;
    logic                busy;
    logic                done;
    logic [RESULT_W-1:0] result;

    modport ctrl   (output start, channel, oversampling_ratio, corrupt,
                    input  busy, done, result);
    modport engine (input  start, channel, oversampling_ratio, corrupt,
                    output busy, done, result);
endinterface : conv_if
